// [common/pld_pkg.sv]
// constants and carrier types for the programmable decode and logic array
// Contract
// R1: two read-only 8-bit memory id registers live in the configuration space
// R2: with fast bit 3 of power_mgmt_reg0 clear, arrays go standby when idle
// R3: inputs unchanged for about 70 ns count as idle
// R4: fast mode off saves power but lengthens propagation delay
// R5: five power_mgmt_reg2 bits block control inputs; only for unused inputs
// R6: shared input bus has 82 signals: address, control, reset, power-down, ports
// R7: bus also carries page bits, both feedback groups and secondary ready/busy
// R8: in 20-bit address mode the address inputs are bits 19 down to 4
// R9: eight primary sector selects, up to three product terms each
// R10: four secondary sector selects, up to three product terms each
// R11: one sram select from up to three product terms
// R12: one select for the configuration register space
// R13: one test-port select that enables in-system programming
// R14: two peripheral selects for peripheral i/o mode
// R15: three external chip selects without any output cell
// R16: the general logic and array forms up to 137 product terms
// R17: sixteen output cells and twenty-four input cells around the and array
// R18: software loads output cells and reads back input and output cells
// R19: logic configuration is fixed and active from reset, no loading step
// R20: host uses control 1 as data read and control 2 as program fetch
// R21: page register read and written at offset e0h of configuration space
// R22: each select is the or of its product terms over the input bus
package pld_pkg;

  localparam int IN_W    = 82;
  localparam int NT      = 3;
  localparam int N_SEL   = 20;
  localparam int N_CELL  = 16;
  localparam int N_EVAL  = N_SEL + N_CELL;
  localparam int PT_MAX  = 137;

  // input bus field positions
  localparam int B_ADDR  = 0;
  localparam int B_CNTL  = 16;
  localparam int B_RST   = 19;
  localparam int B_PDN   = 20;
  localparam int B_PA    = 21;
  localparam int B_PB    = 29;
  localparam int B_PC    = 37;
  localparam int B_PD    = 45;
  localparam int B_PF    = 49;
  localparam int B_PAGE  = 57;
  localparam int B_FBA   = 65;
  localparam int B_FBB   = 73;
  localparam int B_RDY   = 81;

  // register byte offsets
  localparam logic [7:0] OFF_IMC_A = 8'h10;
  localparam logic [7:0] OFF_IMC_B = 8'h14;
  localparam logic [7:0] OFF_IMC_C = 8'h18;
  localparam logic [7:0] OFF_OMC_A = 8'h20;
  localparam logic [7:0] OFF_OMC_B = 8'h24;
  localparam logic [7:0] OFF_STAT  = 8'h30;
  localparam logic [7:0] OFF_PM0   = 8'hb0;
  localparam logic [7:0] OFF_PM2   = 8'hb8;
  localparam logic [7:0] OFF_PAGE  = 8'he0;
  localparam logic [7:0] OFF_ID0   = 8'hf0;
  localparam logic [7:0] OFF_ID1   = 8'hf4;

  localparam int         FAST_BIT  = 3;
  localparam logic [7:0] PM0_RST   = 8'h00;
  localparam logic [4:0] PM2_RST   = 5'h00;
  localparam logic [7:0] PAGE_RST  = 8'h00;

  // idle time before standby, least time so rounded up
  localparam int IDLE_NS  = 70;
  localparam int CLK_NS   = 25;
  localparam int IDLE_CYC = (IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W    = 3;

  typedef struct packed {
    logic [19:0] addr;
    logic [2:0]  cntl;
    logic        rst;
    logic        power_down_input;
    logic [7:0]  pa;
    logic [7:0]  pb;
    logic [7:0]  pc;
    logic [3:0]  pd;
    logic [7:0]  pf;
    logic        rdy;
  } pin_in_t;

  typedef struct packed {
    logic [2:0] ext_cs;
    logic [1:0] periph;
    logic       jtag;
    logic       cfg;
    logic       sram;
    logic [3:0] secondary;
    logic [7:0] primary;
  } sel_out_t;

endpackage : pld_pkg

// [rtl/pterm_sum.sv]
// one sum of product terms over the shared input bus
`timescale 1ns/10ps
module pterm_sum #(
  parameter int W = 82,
  parameter int N = 3
) (
  input  wire logic [W-1:0]   in_bus,
  input  wire logic [N*W-1:0] care,
  input  wire logic [N*W-1:0] want,
  input  wire logic [N-1:0]   en,
  output logic                hit
);
  logic [N-1:0] term;

  // a disabled term never fires, so an empty equation stays low
  for (genvar t = 0; t < N; t++) begin : g_term
    assign term[t] = en[t] & ((in_bus & care[t*W +: W]) == (want[t*W +: W] & care[t*W +: W]));
  end

  assign hit = |term; // [R22]

endmodule : pterm_sum

// [rtl/pld_array.sv]
// decode array, general logic array, page register and power control behind apb
`timescale 1ns/10ps
module pld_array
  import pld_pkg::*;
#(
  parameter logic [N_EVAL*NT*IN_W-1:0] TERM_CARE = '0,
  parameter logic [N_EVAL*NT*IN_W-1:0] TERM_WANT = '0,
  parameter logic [N_EVAL*NT-1:0]      TERM_EN   = '0,
  parameter logic [7:0]                MEM_ID0   = 8'h00,
  parameter logic [7:0]                MEM_ID1   = 8'h00
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire pin_in_t     pins,
  input  wire logic        wide_addr_mode,
  output sel_out_t         selects,
  output logic [7:0]       cell_a,
  output logic [7:0]       cell_b,
  output logic             standby
);

  pin_in_t          pins_m_q;
  pin_in_t          pins_s_q;
  logic             wide_m_q;
  logic             wide_s_q;
  logic [IN_W-1:0]  in_bus;
  logic [IN_W-1:0]  prev_q;
  logic [CNT_W-1:0] idle_cnt_q;
  logic             standby_q;
  logic [7:0]       pm0_q;
  logic [4:0]       pm2_q;
  logic [7:0]       page_q;
  logic [7:0]       cell_a_q;
  logic [7:0]       cell_b_q;
  logic [N_EVAL-1:0] hit;
  logic [N_SEL-1:0] stage_q;
  logic [N_SEL-1:0] sel_q;
  logic [31:0]      prdata_q;
  logic             pready_q;
  logic             pslverr_q;
  logic [31:0]      rd_d;
  logic             hit_reg;
  logic [7:0]       off;
  logic             setup;
  logic             wr_go;
  logic             fast;
  logic [15:0]      addr_in;
  logic [2:0]       cntl_in;
  logic             rst_in;
  logic             pdn_in;

  // pins come from outside the clock domain: two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_m_q <= '0;
      pins_s_q <= '0;
      wide_m_q <= 1'b0;
      wide_s_q <= 1'b0;
    end else begin
      pins_m_q <= pins;
      pins_s_q <= pins_m_q;
      wide_m_q <= wide_addr_mode;
      wide_s_q <= wide_m_q;
    end
  end

  assign fast    = pm0_q[FAST_BIT];
  assign addr_in = wide_s_q ? pins_s_q.addr[19:4] : pins_s_q.addr[15:0]; // [R8]
  // blocked control inputs read as low; only safe when no equation uses them
  assign cntl_in = pins_s_q.cntl & ~pm2_q[2:0]; // [R5]
  assign rst_in  = pins_s_q.rst & ~pm2_q[3]; // [R5]
  assign pdn_in  = pins_s_q.power_down_input & ~pm2_q[4]; // [R5]

  // control 1 is the data read strobe, control 2 the program fetch strobe [R20]
  assign in_bus = {pins_s_q.rdy, cell_b_q, cell_a_q, page_q, pins_s_q.pf, pins_s_q.pd,
                   pins_s_q.pc, pins_s_q.pb, pins_s_q.pa, pdn_in, rst_in, cntl_in,
                   addr_in}; // [R6] [R7]

  // configuration is parameters, live from the first clock with nothing to load
  for (genvar s = 0; s < N_EVAL; s++) begin : g_eval // [R19]
    pterm_sum #(
      .W (IN_W),
      .N (NT)
    ) u_sum (
      .in_bus (in_bus),
      .care   (TERM_CARE[s*NT*IN_W +: NT*IN_W]),
      .want   (TERM_WANT[s*NT*IN_W +: NT*IN_W]),
      .en     (TERM_EN[s*NT +: NT]),
      .hit    (hit[s])
    ); // [R9] [R10] [R11] [R12] [R13] [R14] [R15] [R17] [R22]
  end

  // idle detection over the whole bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q     <= '0;
      idle_cnt_q <= '0;
    end else begin
      prev_q <= in_bus;
      if (in_bus != prev_q) begin
        idle_cnt_q <= '0;
      end else if (idle_cnt_q < CNT_W'(IDLE_CYC)) begin
        idle_cnt_q <= idle_cnt_q + CNT_W'(1); // [R3]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= !fast && (in_bus == prev_q) && (idle_cnt_q >= CNT_W'(IDLE_CYC - 1)); // [R2]
    end
  end

  // slow mode adds a stage; standby freezes both stages to save toggling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_q <= '0;
      sel_q   <= '0;
    end else if (!standby_q) begin
      stage_q <= hit[N_SEL-1:0];
      sel_q   <= fast ? hit[N_SEL-1:0] : stage_q; // [R4]
    end
  end

  // apb decode
  assign off   = paddr[7:0];
  assign setup = psel && !penable;
  assign wr_go = psel && penable && pready_q && pwrite && !pslverr_q;

  // output cells: a bus load wins over the array equation [R18]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_a_q <= '0;
      cell_b_q <= '0;
    end else begin
      if (wr_go && off == OFF_OMC_A && pstrb[0]) begin
        cell_a_q <= pwdata[7:0]; // [R18]
      end else begin
        cell_a_q <= hit[N_SEL +: 8]; // [R17]
      end
      if (wr_go && off == OFF_OMC_B && pstrb[0]) begin
        cell_b_q <= pwdata[7:0]; // [R18]
      end else begin
        cell_b_q <= hit[N_SEL+8 +: 8]; // [R17]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= PAGE_RST;
    end else if (wr_go && off == OFF_PAGE && pstrb[0]) begin
      page_q <= pwdata[7:0]; // [R21]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm0_q <= PM0_RST;
      pm2_q <= PM2_RST;
    end else begin
      if (wr_go && off == OFF_PM0 && pstrb[0]) begin
        pm0_q <= pwdata[7:0]; // [R2]
      end
      if (wr_go && off == OFF_PM2 && pstrb[0]) begin
        pm2_q <= pwdata[4:0]; // [R5]
      end
    end
  end

  // read mux; id registers ignore writes
  always_comb begin
    rd_d = 32'h0000_0000;
    case (off)
      OFF_IMC_A: rd_d[7:0] = pins_s_q.pa; // [R18]
      OFF_IMC_B: rd_d[7:0] = pins_s_q.pb; // [R18]
      OFF_IMC_C: rd_d[7:0] = pins_s_q.pc; // [R18]
      OFF_OMC_A: rd_d[7:0] = cell_a_q; // [R18]
      OFF_OMC_B: rd_d[7:0] = cell_b_q; // [R18]
      OFF_STAT:  rd_d[0]   = standby_q;
      OFF_PM0:   rd_d[7:0] = pm0_q;
      OFF_PM2:   rd_d[4:0] = pm2_q;
      OFF_PAGE:  rd_d[7:0] = page_q; // [R21]
      OFF_ID0:   rd_d[7:0] = MEM_ID0; // [R1]
      OFF_ID1:   rd_d[7:0] = MEM_ID1; // [R1]
      default:   rd_d      = 32'h0000_0000;
    endcase
  end

  always_comb begin
    hit_reg = 1'b1;
    case (off)
      OFF_IMC_A, OFF_IMC_B, OFF_IMC_C, OFF_OMC_A, OFF_OMC_B, OFF_STAT,
      OFF_PM0, OFF_PM2, OFF_PAGE, OFF_ID0, OFF_ID1: hit_reg = 1'b1;
      default: hit_reg = 1'b0;
    endcase
    if (paddr[31:8] != 24'h00_0000 || paddr[1:0] != 2'h0) begin
      hit_reg = 1'b0;
    end
  end

  // no wait state: answer prepared in the setup cycle, given in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !hit_reg;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign selects = sel_out_t'(sel_q);
  assign cell_a  = cell_a_q;
  assign cell_b  = cell_b_q;
  assign standby = standby_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a configuration with more terms than the and array holds is reported as an error at time zero
  initial begin
    if (N_EVAL * NT > PT_MAX) begin // [R16]
      $error("product term count above array capacity");
    end
  end

  a_id_read: assert property (setup && !pwrite && off == OFF_ID0 && paddr[31:8] == 24'h0
      && paddr[1:0] == 2'h0 |=> prdata == {24'h0, MEM_ID0}) // [R1]
    else $error("id0 read wrong");

  a_fast_no_standby: assert property (fast |=> !standby_q) // [R2]
    else $error("standby while fast");

  a_idle_standby: assert property ((!fast && in_bus == prev_q)[*5] |=> standby_q) // [R3]
    else $error("no standby after idle");

  a_slow_delay: assert property (!fast && !standby_q && $stable(pm0_q) ##1 !standby_q && !fast
      |=> sel_q == $past(hit[N_SEL-1:0], 2)) // [R4]
    else $error("slow path delay wrong");

  a_fast_path: assert property (fast && !standby_q |=> sel_q == $past(hit[N_SEL-1:0])) // [R4]
    else $error("fast path delay wrong");

  a_ctl_block: assert property (pm2_q[1] |-> !in_bus[B_CNTL+1]) // [R5]
    else $error("blocked control leaked");

  a_addr_mode: assert property (wide_s_q |-> in_bus[15:0] == pins_s_q.addr[19:4]) // [R8]
    else $error("wide address mapping wrong");

  a_page_write: assert property (wr_go && off == OFF_PAGE && pstrb[0]
      |=> page_q == $past(pwdata[7:0])) // [R21]
    else $error("page write lost");

  a_omc_load: assert property (wr_go && off == OFF_OMC_A && pstrb[0]
      |=> cell_a_q == $past(pwdata[7:0])) // [R18]
    else $error("cell load lost");

  a_bad_addr: assert property (setup && !hit_reg |=> pready && pslverr)
    else $error("unmapped access not flagged");

  c_standby:   cover property (!standby_q ##1 standby_q);
  c_page_wr:   cover property (wr_go && off == OFF_PAGE);
  c_cell_load: cover property (wr_go && off == OFF_OMC_B);
  c_slow_sel:  cover property (!fast && $rose(sel_q[0]));

endmodule : pld_array

// [bench/mcu_pin_model.sv]
// pin-level model of the host bus and ports that feed the logic arrays
`timescale 1ns/10ps
module mcu_pin_model
  import pld_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire pin_in_t    want,
  input  wire logic [1:0] strobe,
  output pin_in_t         pins
);
  pin_in_t p;

  // one strobe at a time, so both address spaces are never selected together
  always_comb begin
    p      = want;
    p.cntl = {strobe == 2'd2, strobe == 2'd1, 1'b0};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pins <= '0;
    else pins <= p;
  end
endmodule : mcu_pin_model

// [bench/tb_top.sv]
// self-checking bench for the decode and logic array
`timescale 1ns/10ps
module tb_top;
  import pld_pkg::*;
  localparam int TW = N_EVAL*NT*IN_W;
  localparam logic [N_EVAL*NT-1:0] TEN = 108'h1008_0010_0000_0001;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wide, standby, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  cell_a, pg;
  logic [1:0]  strobe;
  pin_in_t     want, pins, w;
  sel_out_t    selects;
  int          n_errors, cmp_count;

  // terms: primary 0 on addr 8xxx, sram on page 5a, ext cs 0 on pd a, cell a0 = pa0
  function automatic logic [TW-1:0] mk(input int k);
    logic [TW-1:0] v;
    v = '0;
    v[B_ADDR+12 +: 4]      = k ? 4'h8 : 4'hf;
    v[36*IN_W+B_PAGE +: 8] = k ? 8'h5a : 8'hff;
    v[51*IN_W+B_PD +: 4]   = k ? 4'ha : 4'hf;
    v[60*IN_W+B_PA]        = 1'b1;
    return v;
  endfunction : mk

  function automatic sel_out_t exp_sel(input pin_in_t p, input logic [7:0] g, input logic m);
    logic [15:0] a;
    sel_out_t    s;
    a            = m ? p.addr[19:4] : p.addr[15:0];
    s            = '0;
    s.primary[0] = a[15:12] == 4'h8;
    s.sram       = g == 8'h5a;
    s.ext_cs[0]  = p.pd == 4'ha;
    return s;
  endfunction : exp_sel

  pld_array #(
    .TERM_CARE (mk(0)),
    .TERM_WANT (mk(1)),
    .TERM_EN   (TEN)
  ) u_pld_array (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .wide_addr_mode(wide), .selects(selects),
    .cell_a(cell_a), .cell_b(), .standby(standby)
  );

  mcu_pin_model u_mcu_pin_model (
    .pclk(pclk), .presetn(presetn), .want(want), .strobe(strobe), .pins(pins)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // waits on pready with a bound; the idle cycle after keeps strobes from double driving
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // look at the answer mid-cycle, where it has settled, then finish at the next edge
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic results();
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    results();
  end

  initial begin
    logic [7:0] offs [6];
    offs = '{OFF_PM0, OFF_PM2, OFF_PAGE, OFF_ID0, OFF_ID1, OFF_OMC_B};
    {presetn, psel, penable, pwrite, wide, er} = '0;
    {paddr, pwdata, rd, strobe, want, w, pg} = '0;
    pstrb = 4'hf;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(32'h6deb));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[j]) begin
      apb(1'b0, {24'h0, offs[j]}, 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, OFF_ID0, 32'hff);
    apb(1'b0, OFF_ID0, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 32'h44, 32'h1);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 32'he1, 32'h0);
    chk({31'h0, er}, 32'h1);
    pstrb <= 4'h0;
    apb(1'b1, OFF_PAGE, 32'h33);
    pstrb <= 4'hf;
    apb(1'b0, OFF_PAGE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFF_PM2, 32'h1f);
    apb(1'b0, OFF_PM2, 32'h0);
    chk(rd, 32'h1f);
    // controls feed none of the terms under test, but none is left blocked
    apb(1'b1, OFF_PM2, 32'h0);
    apb(1'b1, OFF_PM0, 32'h08);
    apb(1'b0, OFF_PM0, 32'h0);
    chk(rd, 32'h08);
    for (int i = 0; i < 40; i++) begin
      if (i == 20) apb(1'b1, OFF_PM0, 32'h0);
      pg = ($urandom % 2) ? 8'h5a : 8'($urandom);
      apb(1'b1, OFF_PAGE, {24'h0, pg});
      w = $bits(pin_in_t)'({$urandom, $urandom});
      if (i % 3 == 0) w.addr[19:12] = 8'h88;
      if (i % 4 == 0) w.pd = 4'ha;
      want   <= w;
      wide   <= i[0];
      strobe <= 2'($urandom % 3);
      repeat (8) @(posedge pclk);
      chk(32'(selects), 32'(exp_sel(w, pg, i[0])));
      chk({24'h0, cell_a}, {31'h0, w.pa[0]});
      apb(1'b0, OFF_IMC_A, 32'h0);
      chk(rd, {24'h0, w.pa});
      apb(1'b0, OFF_OMC_A, 32'h0);
      chk(rd, {31'h0, w.pa[0]});
    end
    repeat (10) @(posedge pclk);
    chk({31'h0, standby}, 32'h1);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, OFF_PM0, 32'h08);
    repeat (3) @(posedge pclk);
    chk({31'h0, standby}, 32'h0);
    results();
  end
endmodule : tb_top
